//--- include/mrz_pkg.sv
// Shared constants and types for the mode register zero block.
package mrz_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    // Power-down exit times, in picoseconds, plain defaults.
    localparam int T_XP_PS = 6000;
    localparam int T_XPDLL_PS = 24000;
    // Least times round up to whole cycles, never below one.
    localparam int XP_CYC_RAW = (T_XP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int XPDLL_CYC_RAW =
        (T_XPDLL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] XP_CYC = 8'(XP_CYC_RAW < 1 ? 1 : XP_CYC_RAW);
    localparam logic [7:0] XPDLL_CYC =
        8'(XPDLL_CYC_RAW < 1 ? 1 : XPDLL_CYC_RAW);

    // ------------------------------------------------------------------
    // Command and address layout
    // ------------------------------------------------------------------
    localparam logic [2:0] BANK_MODE_ZERO = 3'h0;
    localparam int ADDR_W = 16;
    localparam int BIT_BL_LO = 0;
    localparam int BIT_CL_LO = 2;
    localparam int BIT_BT = 3;
    localparam int BIT_CL_F0 = 4;
    localparam int BIT_CL_F2 = 6;
    localparam int BIT_TM = 7;
    localparam int BIT_DLL = 8;
    localparam int BIT_WR_F0 = 9;
    localparam int BIT_WR_F2 = 11;
    localparam int BIT_PPD = 12;
    localparam int BIT_BC_OTF = 12;
    localparam logic [15:0] MODE_ZERO_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Field decoding
    // ------------------------------------------------------------------
    localparam logic [4:0] CL_LO_BASE = 5'h04;
    localparam logic [4:0] CL_HI_BASE = 5'h0b;
    localparam logic [4:0] WR_LO_BASE = 5'h04;
    localparam logic [4:0] WR_MAX = 5'h10;
    localparam logic [2:0] WR_LO_TOP = 3'h4;
    localparam logic [1:0] LAST_PAIR = 2'h3;
    localparam logic [1:0] BC4_WR_PAIR = 2'h1;
    localparam logic [5:0] RL_PIPE = 6'h02;

    // Burst length codes follow the declaration order.
    typedef enum logic [1:0] {
        MRZ_BL8_FIXED,
        MRZ_BL_OTF,
        MRZ_BC4_FIXED,
        MRZ_BL_RSVD
    } mrz_bl_t;

    typedef enum logic [1:0] {
        MRZ_RD_IDLE,
        MRZ_RD_WAIT,
        MRZ_RD_BURST
    } mrz_rd_t;

endpackage

//--- rtl/mrz_order.sv
// Column ordering for one pair of beats of a burst.
`timescale 1ns/1ps
module mrz_order
    import mrz_pkg::*;
(
    input wire logic [2:0] start_col,
    input wire logic [1:0] pair,
    input wire logic interleave,
    input wire logic is_write,
    input wire logic chop,
    output logic [2:0] col_even,
    output logic [2:0] col_odd
);

    // ------------------------------------------------------------------
    // Ordering function
    // ------------------------------------------------------------------
    // Returns the column that lands on the given beat of the burst.
    function automatic logic [2:0] beat_col(input logic [2:0] start,
                                            input logic [2:0] beat,
                                            input logic ilv,
                                            input logic wr,
                                            input logic bc4);
        logic [1:0] low;
        low = start[1:0] + beat[1:0];
        if (wr) begin
            // Writes ignore the low start bits altogether. [R8]
            beat_col = bc4 ? {start[2], beat[1:0]} : beat; // [R8]
        end else if (ilv) begin
            beat_col = start ^ beat; // [R6]
        end else begin
            // Wrap inside the nibble, then move to the other one. [R6]
            beat_col = {start[2] ^ beat[2], low}; // [R6]
        end
    endfunction

    // Two beats per clock, so a pair is one clock of data.
    assign col_even = beat_col(start_col, {pair, 1'b0}, interleave,
                               is_write, chop);
    assign col_odd = beat_col(start_col, {pair, 1'b1}, interleave,
                              is_write, chop);

endmodule // mrz_order

//--- rtl/mrz_mode_reg.sv
// Mode register zero and the read, write and power-down logic it steers.
//
// Rules for this block and for the controller that drives it
// R1: Controller rewrites register only while idle.
// R2: All command lows plus bank zero select it.
// R3: Controller drives reserved bits to zero.
// R4: Bit three picks sequential or interleaved order.
// R5: Low bits pick chop, eight, or on-the-fly.
// R6: Read order follows start column and type.
// R7: Chopped read tri-states last four beat slots.
// R8: Write order ignores start, chop uses bit two.
// R9: Fixed chop write finishes two clocks earlier.
// R10: CAS latency from bits two, four to six.
// R11: Read latency is additive plus CAS latency.
// R12: Controller keeps test mode bit at zero.
// R13: DLL reset bit clears itself after use.
// R14: Controller waits lock time after DLL reset.
// R15: Write recovery plus precharge gives tDAL.
// R16: Controller programs recovery at least tWR.
// R17: Slow exit freezes DLL, needs long exit.
// R18: Fast exit keeps DLL, needs short exit.
// R19: Bit eight high requests a DLL reset.
// R20: Every register write supplies all fields.
// R21: Controller spaces register writes by tMRD.
// R22: Controller waits tMOD before other commands.
// R23: Codes: eight, on-the-fly, chop, reserved.
`timescale 1ns/1ps
module mrz_mode_reg
    import mrz_pkg::*;
#(
    parameter int TRP_CYCLES = 11
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr,
    input wire logic [4:0] additive_latency,
    output logic [15:0] mode_register_zero,
    output logic [4:0] cas_latency,
    output logic [5:0] read_latency,
    output logic [4:0] write_recovery,
    output logic [5:0] tdal_cycles,
    output logic test_mode,
    output logic dll_reset,
    output logic dll_frozen,
    output logic power_down,
    output logic exit_wait,
    output logic [2:0] rd_col_even,
    output logic [2:0] rd_col_odd,
    output logic rd_dq_oe,
    output logic rd_dqs_oe,
    output logic [2:0] wr_col_even,
    output logic [2:0] wr_col_odd,
    output logic wr_strobe,
    output logic wr_internal
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] decode_cl(input logic [15:0] mr);
        logic [4:0] code;
        code = {2'h0, mr[BIT_CL_F2:BIT_CL_F0]};
        decode_cl = mr[BIT_CL_LO] ? code + CL_HI_BASE : code + CL_LO_BASE;
    endfunction

    function automatic logic [4:0] decode_wr(input logic [15:0] mr);
        logic [2:0] code;
        code = mr[BIT_WR_F2:BIT_WR_F0];
        if (code == 3'h0) begin
            decode_wr = WR_MAX;
        end else if (code <= WR_LO_TOP) begin
            decode_wr = {2'h0, code} + WR_LO_BASE;
        end else begin
            decode_wr = {1'b0, code, 1'b0};
        end
    endfunction

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic busy;
    logic cmd_ok;
    logic is_mrs0;
    logic is_read;
    logic is_write;
    mrz_bl_t bl_mode;
    logic cmd_chop;

    // Pins are sampled on the memory clock itself, so no synchroniser.
    assign cmd_ok = !cs_n && cke && !power_down && !exit_wait;
    assign is_mrs0 = cmd_ok && !ras_n && !cas_n && !we_n
        && ba == BANK_MODE_ZERO; // [R2]
    assign is_read = cmd_ok && ras_n && !cas_n && we_n;
    assign is_write = cmd_ok && ras_n && !cas_n && !we_n;
    assign bl_mode = mrz_bl_t'(mode_register_zero[BIT_BL_LO+1:BIT_BL_LO]);
    // Reserved length code behaves as fixed eight.
    assign cmd_chop = bl_mode == MRZ_BC4_FIXED
        || (bl_mode == MRZ_BL_OTF && !addr[BIT_BC_OTF]); // [R5] [R23]

    // ------------------------------------------------------------------
    // Mode register and DLL reset
    // ------------------------------------------------------------------
    // Whole word is stored; reserved bits are the controller's concern.
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_register_zero <= MODE_ZERO_RESET;
        end else if (is_mrs0 && !busy) begin
            mode_register_zero <= addr; // [R2] [R20]
        end else if (mode_register_zero[BIT_DLL]) begin
            mode_register_zero[BIT_DLL] <= 1'b0; // [R13]
        end
    end

    // The DLL reset runs in the cycle after the write, then the bit clears.
    always_ff @(posedge clk) begin
        if (reset) begin
            dll_reset <= 1'b0;
        end else begin
            dll_reset <= is_mrs0 && !busy && addr[BIT_DLL]; // [R19]
        end
    end

    assign cas_latency = decode_cl(mode_register_zero); // [R10]
    assign read_latency = {1'b0, additive_latency}
        + {1'b0, cas_latency}; // [R11]
    assign write_recovery = decode_wr(mode_register_zero);
    assign tdal_cycles = {1'b0, write_recovery}
        + 6'(TRP_CYCLES); // [R15]
    assign test_mode = mode_register_zero[BIT_TM];

    // ------------------------------------------------------------------
    // Read burst
    // ------------------------------------------------------------------
    mrz_rd_t rd_state;
    logic [5:0] rd_wait;
    logic [1:0] rd_pair;
    logic [2:0] rd_start;
    logic rd_ilv;
    logic rd_chop;
    logic [2:0] rd_even;
    logic [2:0] rd_odd;

    // One read at a time; the controller spaces bursts.
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_state <= MRZ_RD_IDLE;
            rd_wait <= 6'h00;
            rd_pair <= 2'h0;
            rd_start <= 3'h0;
            rd_ilv <= 1'b0;
            rd_chop <= 1'b0;
        end else begin
            case (rd_state)
                MRZ_RD_IDLE: begin
                    if (is_read) begin
                        rd_state <= MRZ_RD_WAIT;
                        rd_wait <= read_latency - RL_PIPE; // [R11]
                        rd_pair <= 2'h0;
                        rd_start <= addr[2:0]; // [R6]
                        rd_ilv <= mode_register_zero[BIT_BT]; // [R4]
                        rd_chop <= cmd_chop; // [R5]
                    end
                end
                MRZ_RD_WAIT: begin
                    if (rd_wait == 6'h00) begin
                        rd_state <= MRZ_RD_BURST;
                    end else begin
                        rd_wait <= rd_wait - 6'h01;
                    end
                end
                MRZ_RD_BURST: begin
                    rd_pair <= rd_pair + 2'h1;
                    if (rd_pair == LAST_PAIR) begin
                        rd_state <= MRZ_RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= MRZ_RD_IDLE;
                end
            endcase
        end
    end

    mrz_order u_rd_order (
        .start_col(rd_start),
        .pair(rd_pair),
        .interleave(rd_ilv),
        .is_write(1'b0),
        .chop(rd_chop),
        .col_even(rd_even),
        .col_odd(rd_odd)
    );

    // Chopped reads keep the slots but float the drivers in the tail.
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_col_even <= 3'h0;
            rd_col_odd <= 3'h0;
            rd_dq_oe <= 1'b0;
        end else if (rd_state == MRZ_RD_BURST) begin
            rd_col_even <= rd_even;
            rd_col_odd <= rd_odd;
            rd_dq_oe <= !(rd_chop && rd_pair[1]); // [R7]
        end else begin
            rd_dq_oe <= 1'b0;
        end
    end
    assign rd_dqs_oe = rd_dq_oe; // [R7]

    // ------------------------------------------------------------------
    // Write burst
    // ------------------------------------------------------------------
    logic wr_active;
    logic [1:0] wr_pair;
    logic [2:0] wr_start;
    logic wr_chop;
    logic wr_fixed_bc4;
    logic [2:0] wr_even;
    logic [2:0] wr_odd;
    logic [1:0] wr_done_pair;

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_active <= 1'b0;
            wr_pair <= 2'h0;
            wr_start <= 3'h0;
            wr_chop <= 1'b0;
            wr_fixed_bc4 <= 1'b0;
        end else if (!wr_active) begin
            if (is_write) begin
                wr_active <= 1'b1;
                wr_pair <= 2'h0;
                wr_start <= addr[2:0]; // [R8]
                wr_chop <= cmd_chop;
                wr_fixed_bc4 <= bl_mode == MRZ_BC4_FIXED; // [R9]
            end
        end else begin
            wr_pair <= wr_pair + 2'h1;
            if (wr_pair == LAST_PAIR) begin
                wr_active <= 1'b0;
            end
        end
    end

    mrz_order u_wr_order (
        .start_col(wr_start),
        .pair(wr_pair),
        .interleave(1'b0),
        .is_write(1'b1),
        .chop(wr_chop),
        .col_even(wr_even),
        .col_odd(wr_odd)
    );

    // Only fixed chop pulls the internal write in; on-the-fly keeps BL8.
    assign wr_done_pair = wr_fixed_bc4 ? BC4_WR_PAIR : LAST_PAIR; // [R9]

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_col_even <= 3'h0;
            wr_col_odd <= 3'h0;
            wr_strobe <= 1'b0;
            wr_internal <= 1'b0;
        end else begin
            wr_col_even <= wr_even;
            wr_col_odd <= wr_odd;
            wr_strobe <= wr_active && !(wr_chop && wr_pair[1]); // [R8]
            wr_internal <= wr_active && wr_pair == wr_done_pair; // [R9]
        end
    end

    assign busy = rd_state != MRZ_RD_IDLE || wr_active;

    // ------------------------------------------------------------------
    // Precharge power-down
    // ------------------------------------------------------------------
    logic cke_q;
    logic [7:0] exit_cnt;

    // Entry only when idle; exit wait depends on the DLL choice.
    always_ff @(posedge clk) begin
        if (reset) begin
            cke_q <= 1'b0;
            power_down <= 1'b0;
            exit_wait <= 1'b0;
            exit_cnt <= 8'h00;
        end else begin
            cke_q <= cke;
            if (!power_down && cke_q && !cke && !busy) begin
                power_down <= 1'b1;
            end else if (power_down && cke) begin
                power_down <= 1'b0;
                exit_wait <= 1'b1;
                exit_cnt <= mode_register_zero[BIT_PPD]
                    ? XP_CYC : XPDLL_CYC; // [R17] [R18]
            end else if (exit_wait) begin
                exit_cnt <= exit_cnt - 8'h01;
                exit_wait <= exit_cnt != 8'h01;
            end
        end
    end
    assign dll_frozen = power_down && !mode_register_zero[BIT_PPD]; // [R17]

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [5:0] lat_cnt;
    logic [5:0] rl_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            lat_cnt <= 6'h00;
            rl_q <= 6'h00;
        end else if (is_read && rd_state == MRZ_RD_IDLE) begin
            lat_cnt <= 6'h00;
            rl_q <= read_latency;
        end else begin
            lat_cnt <= lat_cnt + 6'h01;
        end
    end

    sequence s_dll_req;
        is_mrs0 && !busy && addr[BIT_DLL];
    endsequence
    sequence s_dll_run;
        dll_reset && mode_register_zero[BIT_DLL]
            ##1 !mode_register_zero[BIT_DLL];
    endsequence

    a_dll_self_clear: assert property (s_dll_req |=> s_dll_run) // [R13]
        else $error("DLL reset bit did not clear itself");
    a_mrs_capture: assert property (is_mrs0 && !busy |=> // [R2]
        mode_register_zero[7:0] == $past(addr[7:0]))
        else $error("mode register zero write not captured");
    a_read_latency: assert property ($rose(rd_dq_oe) |-> // [R11]
        lat_cnt == rl_q)
        else $error("read data not at AL plus CL");
    a_chop_hiz: assert property ($rose(rd_dq_oe) && rd_chop |-> // [R7]
        ##1 rd_dq_oe ##1 !rd_dq_oe ##1 !rd_dq_oe)
        else $error("chopped read drove tail slots");
    a_read_first: assert property ($rose(rd_dq_oe) |-> // [R6]
        rd_col_even == rd_start)
        else $error("first read beat not the start column");
    a_write_order: assert property (wr_strobe && !wr_chop |-> // [R8]
        wr_col_even == {$past(wr_pair), 1'b0})
        else $error("eight beat write not in order");
    a_bc4_early: assert property (wr_active && wr_pair == 2'h0 // [R9]
        && wr_fixed_bc4 |-> ##2 wr_internal)
        else $error("fixed chop write not two clocks early");
    a_exit_slow: assert property (power_down && cke // [R17]
        && !mode_register_zero[BIT_PPD] |=> exit_wait [*3])
        else $error("slow exit wait too short");
    // Entry is checked from the pins, not from the freeze expression.
    a_pd_freeze: assert property ($fell(cke) && !busy // [R17]
        && !power_down && !mode_register_zero[BIT_PPD] |=> dll_frozen)
        else $error("DLL not frozen after slow exit power-down entry");
    a_exit_fast: assert property (power_down && cke // [R18]
        && mode_register_zero[BIT_PPD] |=> exit_wait ##1 !exit_wait)
        else $error("fast exit wait not one cycle");

endmodule // mrz_mode_reg

//--- dv/mrz_ctl_model.sv
// Behavioural memory controller that drives the command pins of the block.
`timescale 1ns/1ps
module mrz_ctl_model
    import mrz_pkg::*;
#(
    parameter int T_MOD = 12,
    parameter int T_DLLK = 24,
    parameter int T_WR_PS = 15000
) (
    input wire logic clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic [15:0] addr
);
    // Deselected with clock enabled from time zero.
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h7;
        addr = 16'hffff;
    end

    // One command for one clock; a deselected bus shows inverted leftovers,
    // so a design that samples it late sees garbage, not stale data.
    task automatic cmd(input logic [2:0] c, input logic [2:0] b,
                       input logic [15:0] a);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
        ba = b;
        addr = a;
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = ~b;
        addr = ~a;
    endtask

    // Recovery must cover tWR rounded up to whole cycles.
    localparam int WR_MIN_CYC =
        (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Rows are never opened here, so every MRS lands on an idle device.
    // Reserved bits and the test bit are forced to zero; a recovery code
    // that is too short is replaced by the longest one.
    task automatic mrs(input logic [15:0] a);
        if (a[BIT_WR_F2:BIT_WR_F0] != 3'h0
            && int'(a[BIT_WR_F2:BIT_WR_F0]) + 4 < WR_MIN_CYC) begin
            a[BIT_WR_F2:BIT_WR_F0] = 3'h0;
        end
        cmd(3'h0, BANK_MODE_ZERO,
            a & 16'h1f7f);
        // The tMOD wait is longer than tMRD, so it covers both.
        repeat (T_MOD) @(negedge clk);
        if (a[BIT_DLL]) begin
            repeat (T_DLLK) @(negedge clk);
        end
    endtask

    task automatic rd(input logic [2:0] col, input logic a12);
        cmd(3'h5, 3'h0, {3'h0, a12, 9'h000, col});
    endtask

    task automatic wr(input logic [2:0] col, input logic a12);
        cmd(3'h4, 3'h0, {3'h0, a12, 9'h000, col});
    endtask

    // Always waits the slow exit time, which satisfies either mode.
    task automatic pd_cycle(input int n);
        @(negedge clk);
        cke = 1'b0;
        repeat (n) @(negedge clk);
        cke = 1'b1;
        repeat (XPDLL_CYC + 2) @(negedge clk);
    endtask
endmodule // mrz_ctl_model

//--- dv/test_ddr3_mode_reg_zero_burst_order.sv
// Self-checking testbench for the mode register zero block.
`timescale 1ns/1ps
module test_ddr3_mode_reg_zero_burst_order
    import mrz_pkg::*;
;
    localparam logic [4:0] AL = 5'h02;
    localparam int RL = 7;
    logic clk, reset, cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0] ba, rd_col_even, rd_col_odd, wr_col_even, wr_col_odd;
    logic [15:0] addr, mode_register_zero;
    logic [4:0] additive_latency, cas_latency, write_recovery;
    logic [5:0] read_latency, tdal_cycles;
    logic test_mode, dll_reset, dll_frozen, power_down, exit_wait;
    logic rd_dq_oe, rd_dqs_oe, wr_strobe, wr_internal;
    logic pd_seen, frz_seen;
    int err_count, cmp_count, dll_cnt, ew_cnt;

    mrz_mode_reg #(.TRP_CYCLES(11)) i_dut (
        .clk(clk), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
        .additive_latency(additive_latency),
        .mode_register_zero(mode_register_zero), .cas_latency(cas_latency),
        .read_latency(read_latency), .write_recovery(write_recovery),
        .tdal_cycles(tdal_cycles), .test_mode(test_mode),
        .dll_reset(dll_reset), .dll_frozen(dll_frozen),
        .power_down(power_down), .exit_wait(exit_wait),
        .rd_col_even(rd_col_even), .rd_col_odd(rd_col_odd),
        .rd_dq_oe(rd_dq_oe), .rd_dqs_oe(rd_dqs_oe),
        .wr_col_even(wr_col_even), .wr_col_odd(wr_col_odd),
        .wr_strobe(wr_strobe), .wr_internal(wr_internal)
    );

    mrz_ctl_model i_ctl (
        .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr)
    );

    // ------------------------------------------------------------------
    // Clock, monitors and helpers
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // Pulses and levels are tallied so that short events are not missed.
    always @(negedge clk) begin
        if (dll_reset === 1'b1) dll_cnt++;
        if (exit_wait === 1'b1) ew_cnt++;
        if (power_down === 1'b1) pd_seen = 1'b1;
        if (dll_frozen === 1'b1) frz_seen = 1'b1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Column of beat b for start s in sequential or interleaved order.
    function automatic logic [2:0] ord(input logic [2:0] s,
                                       input logic [2:0] b, input logic i);
        if (i) return s ^ b;
        return {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Roughly thirteen hundred cycles are expected; this leaves ample margin.
    initial begin
        repeat (8000) @(posedge clk);
        err_count++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [1:0] md, code;
        logic [2:0] s, base;
        logic a12, chop, on;
        int cl, wrv, p;
        reset = 1'b1;
        additive_latency = AL;
        {err_count, cmp_count, dll_cnt, ew_cnt} = '0;
        {pd_seen, frz_seen} = 2'b00;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        check(mode_register_zero, MODE_ZERO_RESET);
        check(16'({power_down, exit_wait, dll_reset, rd_dq_oe, wr_strobe}),
              16'h0000);
        $display("test reset_values done");

        dll_cnt = 0;
        i_ctl.mrs(16'h0100);
        check(16'(dll_cnt), 16'h0001);
        check(mode_register_zero, 16'h0000);
        i_ctl.cmd(3'h0, 3'h1, 16'h0010);
        repeat (i_ctl.T_MOD) @(negedge clk);
        check(mode_register_zero, 16'h0000);
        $display("test dll_reset_and_select done");

        for (int i = 0; i < 8; i++) begin
            a = {4'h0, i[2:0], 2'b00, i[2:0], 1'b0, i[0], 2'b00};
            cl = i[0] ? i + 11 : i + 4;
            wrv = (i == 0) ? 16 : (i <= 4) ? i + 4 : i * 2;
            // Additive latency is swept too, so the sum is really tested.
            additive_latency = 5'(i);
            i_ctl.mrs(a);
            check(mode_register_zero, a);
            check(16'(cas_latency), 16'(cl));
            check(16'(read_latency), 16'(cl + i));
            check(16'(write_recovery), 16'(wrv));
            check(16'(tdal_cycles), 16'(wrv + 11));
            check(16'(test_mode), 16'h0000);
        end
        additive_latency = AL;
        $display("test latency_fields done");

        // Bit 0 of m picks the type, bits 2:1 the length mode.
        for (int m = 0; m < 8; m++) begin
            md = m[2:1];
            code = (md == 0) ? 2'h0 : (md == 3) ? 2'h2 : 2'h1;
            a12 = (md == 1);
            chop = (md >= 2);
            i_ctl.mrs({12'h001, m[0], 1'b0, code});
            for (int k = 0; k < 8; k++) begin
                s = k[2:0];
                i_ctl.rd(s, a12);
                for (int c = 1; c <= RL + 4; c++) begin
                    @(negedge clk);
                    p = c - RL;
                    on = (c >= RL) && (p < 4) && (!chop || p < 2);
                    check(16'({rd_dq_oe, rd_dqs_oe}),
                          on ? 16'h3 : 16'h0);
                    if (on)
                        check(16'({rd_col_even, rd_col_odd}),
                              16'({ord(s, 3'(2 * p), m[0]),
                                   ord(s, 3'(2 * p + 1), m[0])}));
                end
            end
            for (int j = 0; j < 2; j++) begin
                s = j ? 3'h6 : 3'h3;
                base = chop ? {s[2], 2'b00} : 3'h0;
                i_ctl.wr(s, a12);
                for (int c = 1; c <= 6; c++) begin
                    @(negedge clk);
                    // Pair p is registered at the edge k + 1 + p.
                    p = c - 1;
                    on = (c <= 4) && (!chop || p < 2);
                    check(16'(wr_strobe), 16'(on));
                    check(16'(wr_internal),
                          16'(c == ((md == 3) ? 2 : 4)));
                    if (on)
                        check(16'({wr_col_even, wr_col_odd}),
                              16'({3'(base + 2 * p),
                                   3'(base + 2 * p + 1)}));
                end
            end
        end
        $display("test burst_order done");

        for (int f = 0; f < 2; f++) begin
            i_ctl.mrs(16'h0010 | (16'(f) << BIT_PPD));
            ew_cnt = 0;
            {pd_seen, frz_seen} = 2'b00;
            i_ctl.pd_cycle(4);
            check(16'(pd_seen), 16'h0001);
            check(16'(frz_seen), 16'(f == 0));
            check(16'(ew_cnt),
                  f ? 16'(XP_CYC) : 16'(XPDLL_CYC));
        end
        $display("test power_down_exit done");
        wrap_up();
    end
endmodule // test_ddr3_mode_reg_zero_burst_order
